// [design/ccdr_fifo.sv]
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module ccdr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic [WIDTH-1:0] next_out_data;
  logic next_out_valid;
  logic do_wr, do_rd;

  // Read data leaves through a register
  always_comb begin
    do_rd = out_valid && out_ready;
    do_wr = in_valid && in_ready;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    next_out_valid = out_valid && !do_rd;
    next_out_data = out_data;
    if ((!out_valid || out_ready) && count != '0) begin
      next_out_valid = 1'b1;
      next_out_data = mem[rd_ptr];
      next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    if (do_wr) begin
      next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    next_count = count + (AW+1)'(do_wr) - (AW+1)'(next_rd_ptr != rd_ptr);
  end

  assign in_ready = (count != (AW+1)'(DEPTH));

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (clk_en) begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      out_valid <= next_out_valid;
      out_data <= next_out_data;
      if (do_wr) begin
        mem[wr_ptr] <= in_data;
      end
    end
  end
endmodule

// [design/ccdr_pkg.sv]
// Constants for the frame-transfer sensor drive sequencer
// What this block does
// - Clear image by pulsing overflow drain for at least one microsecond.
// - Per field issue parallel transfer pulses on all gates: 500, or 501 on interlace field two; progressive fields always 500.
// - Progressive scan selects single-register normal or dual-register fast readout.
// - Storage gate with serial gates moves one line at a time, two in dual-register readout.
// - Pulse detection-node reset before every next pixel reaches the node.
// - Serial timing includes clamp and sample-and-hold strobes for double sampling.
package ccdr_pkg;
  // ****************
  // Timing
  // ****************
  localparam int CLK_MHZ = 250;
  localparam int CLEAR_NS = 1000;
  localparam int CLEAR_CYC = (CLEAR_NS * CLK_MHZ + 999) / 1000;
  // Parallel gate half period and serial quarter period: 25 MHz parallel, 12.5 MHz serial at 250 MHz
  localparam int PAR_HALF = 5;
  localparam int SER_QUARTER = 5;
  // ****************
  // Geometry
  // ****************
  localparam int FIELD1_XFERS = 500;
  localparam int FIELD2_XFERS = 501;
  localparam int ARRAY_LINES = 500;
  localparam int LINE_ELEMS = 680;
  localparam int DARK_COLS = 22;
  localparam int DARK_LINES = 4;
  localparam int DUMMY_ELEMS = 4;
  localparam int LINE_CLOCKS = DUMMY_ELEMS + LINE_ELEMS;
  localparam int VID_W = 12;
  localparam int FIFO_DEPTH = 8;
  // ****************
  // Modes and pixel kinds
  // ****************
  localparam logic [1:0] MODE_INTERLACE = 2'h0;
  localparam logic [1:0] MODE_PROG_SINGLE = 2'h1;
  localparam logic [1:0] MODE_PROG_DUAL = 2'h2;
  localparam logic [1:0] KIND_DUMMY = 2'h0;
  localparam logic [1:0] KIND_DARK = 2'h1;
  localparam logic [1:0] KIND_ACTIVE = 2'h2;
  typedef enum logic [5:0] {
    CCDR_IDLE = 6'h01,
    CCDR_CLEAR = 6'h02,
    CCDR_INTEG = 6'h04,
    CCDR_PXFER = 6'h08,
    CCDR_LXFER = 6'h10,
    CCDR_PIXEL = 6'h20
  } ccdr_state_e;
endpackage

// [design/ccdr_seq.sv]
// Drive sequencer for a frame-transfer CCD sensor and its sample path
`timescale 1ns/10ps
module ccdr_seq
  import ccdr_pkg::*;
#(
  parameter int INTEG_CYCLES = 4096,
  parameter int XFERS_F1 = ccdr_pkg::FIELD1_XFERS,
  parameter int XFERS_F2 = ccdr_pkg::FIELD2_XFERS,
  parameter int LINES = ccdr_pkg::ARRAY_LINES,
  parameter int ELEMS = ccdr_pkg::LINE_ELEMS
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Control
  input wire logic start,
  input wire logic [1:0] mode,
  input wire logic clear_first,
  output logic busy,
  output logic field_two,
  // Sensor gates
  output logic image_gate_a,
  output logic image_gate_b,
  output logic storage_gate,
  output logic [1:0] serial_shift_gate,
  output logic reset_gate,
  output logic overflow_drain_bias,
  // Double-sampling strobes
  output logic clamp_strobe,
  output logic sample_strobe,
  // Digitised video from the converters
  input wire logic [ccdr_pkg::VID_W-1:0] video_out_a,
  input wire logic [ccdr_pkg::VID_W-1:0] video_out_b,
  // Pixel stream
  output logic pix_valid,
  input wire logic pix_ready,
  output logic [2*ccdr_pkg::VID_W-1:0] pix_data,
  output logic [1:0] pix_kind,
  output logic pix_dual
);
  import ccdr_pkg::*;

  localparam int FW = 2 * VID_W + 3;
  ccdr_state_e state, next_state;
  logic [15:0] tmr, next_tmr;
  logic [9:0] cnt, next_cnt;
  logic [9:0] line, next_line;
  logic [1:0] mode_q, next_mode_q;
  logic field_q, next_field_q;
  logic next_ia, next_sa, next_ck;
  logic next_rg, next_cl, next_sh;
  logic [1:0] next_sg;
  logic next_odb;
  logic [VID_W-1:0] va_s1, va_s2, vb_s1, vb_s2;
  logic f_valid, f_ready;
  logic [FW-1:0] f_data, o_data;

  // Pixel kind from serial clock position
  function automatic logic [1:0] kind_of(input logic [9:0] pos);
    if (pos < 10'(DUMMY_ELEMS)) begin
      return KIND_DUMMY;
    end else if (pos < 10'(DUMMY_ELEMS + DARK_COLS)) begin
      return KIND_DARK;
    end
    return KIND_ACTIVE;
  endfunction

  // ****************
  // Video input synchronisers
  // ****************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      va_s1 <= '0;
      va_s2 <= '0;
      vb_s1 <= '0;
      vb_s2 <= '0;
    end else if (clk_en) begin
      va_s1 <= video_out_a;
      va_s2 <= va_s1;
      vb_s1 <= video_out_b;
      vb_s2 <= vb_s1;
    end
  end

  // ****************
  // Sequencer
  // ****************
  always_comb begin
    next_state = state;
    next_tmr = tmr;
    next_cnt = cnt;
    next_line = line;
    next_mode_q = mode_q;
    next_field_q = field_q;
    next_ia = 1'b0;
    next_sa = 1'b0;
    next_ck = 1'b0;
    next_sg = 2'h0;
    next_rg = 1'b0;
    next_cl = 1'b0;
    next_sh = 1'b0;
    next_odb = 1'b0;
    f_valid = 1'b0;
    unique case (state)
      CCDR_IDLE: begin
        next_tmr = '0;
        if (start) begin
          next_mode_q = mode;
          next_state = clear_first ? CCDR_CLEAR : CCDR_INTEG;
        end
      end
      CCDR_CLEAR: begin
        next_odb = 1'b1;
        next_tmr = tmr + 1'b1;
        if (tmr == 16'(CLEAR_CYC - 1)) begin
          // Held through the last count, else the pulse is one cycle short
          next_tmr = '0;
          next_state = CCDR_INTEG;
        end
      end
      CCDR_INTEG: begin
        next_tmr = tmr + 1'b1;
        if (tmr == 16'(INTEG_CYCLES - 1)) begin
          next_tmr = '0;
          next_cnt = '0;
          next_state = CCDR_PXFER;
        end
      end
      CCDR_PXFER: begin
        // Every gate toggles together; interlace adds a pulse on field two
        next_tmr = tmr + 1'b1;
        next_ia = (tmr < 16'(PAR_HALF));
        next_sa = next_ia;
        next_sg = {2{next_ia}};
        if (tmr == 16'(2 * PAR_HALF - 1)) begin
          next_tmr = '0;
          next_cnt = cnt + 1'b1;
          if (cnt == 10'(((mode_q == MODE_INTERLACE && field_q) ? XFERS_F2 : XFERS_F1) - 1))
          begin
            next_cnt = '0;
            next_line = '0;
            next_state = CCDR_LXFER;
          end
        end
      end
      CCDR_LXFER: begin
        // One line from storage into the register(s) in use
        next_tmr = tmr + 1'b1;
        next_sa = (tmr < 16'(PAR_HALF));
        next_sg[1] = next_sa;
        next_sg[0] = next_sa && (mode_q == MODE_PROG_SINGLE || mode_q == MODE_PROG_DUAL);
        if (tmr == 16'(2 * PAR_HALF - 1)) begin
          next_tmr = '0;
          next_cnt = '0;
          next_state = CCDR_PIXEL;
        end
      end
      CCDR_PIXEL: begin
        // Four phases per pixel: reset, clamp, shift, sample; stall on back-pressure
        if (tmr < 16'(SER_QUARTER)) begin
          next_rg = 1'b1;
        end else if (tmr < 16'(2 * SER_QUARTER)) begin
          next_cl = 1'b1;
        end else if (tmr < 16'(3 * SER_QUARTER)) begin
          next_ck = 1'b1;
        end else begin
          next_sh = 1'b1;
        end
        next_sg = {next_ck, next_ck && mode_q != MODE_INTERLACE};
        if (tmr == 16'(4 * SER_QUARTER - 1)) begin
          f_valid = 1'b1;
          if (f_ready) begin
            next_tmr = '0;
            next_cnt = cnt + 1'b1;
            if (cnt == 10'(DUMMY_ELEMS + ELEMS - 1)) begin
              next_line = line + 1'b1;
              next_state = CCDR_LXFER;
              // Dual readout empties two lines per shift
              if ((line + ((mode_q == MODE_PROG_DUAL) ? 10'h002 : 10'h001)) >= 10'(LINES))
              begin
                next_field_q = !field_q;
                next_state = CCDR_IDLE;
              end else if (mode_q == MODE_PROG_DUAL) begin
                next_line = line + 10'h002;
              end
            end
          end
        end else begin
          next_tmr = tmr + 1'b1;
        end
      end
      default: begin
        next_state = CCDR_IDLE;
      end
    endcase
  end

  always_comb begin
    f_data = {kind_of(cnt), mode_q == MODE_PROG_DUAL,
              (mode_q == MODE_INTERLACE) ? va_s2 : vb_s2,
              (mode_q == MODE_INTERLACE) ? vb_s2 : va_s2};
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= CCDR_IDLE;
      tmr <= '0;
      cnt <= '0;
      line <= '0;
      mode_q <= MODE_INTERLACE;
      field_q <= 1'b0;
      image_gate_a <= 1'b0;
      image_gate_b <= 1'b0;
      storage_gate <= 1'b0;
      serial_shift_gate <= 2'h0;
      reset_gate <= 1'b0;
      clamp_strobe <= 1'b0;
      sample_strobe <= 1'b0;
      overflow_drain_bias <= 1'b0;
      busy <= 1'b0;
      field_two <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      tmr <= next_tmr;
      cnt <= next_cnt;
      line <= next_line;
      mode_q <= next_mode_q;
      field_q <= next_field_q;
      image_gate_a <= next_ia;
      image_gate_b <= next_ia;
      storage_gate <= next_sa;
      serial_shift_gate <= next_sg;
      reset_gate <= next_rg;
      clamp_strobe <= next_cl;
      sample_strobe <= next_sh;
      overflow_drain_bias <= next_odb;
      busy <= (next_state != CCDR_IDLE);
      field_two <= next_field_q;
    end
  end

  // ****************
  // Output buffer
  // ****************
  ccdr_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .in_valid(f_valid),
    .in_ready(f_ready),
    .in_data(f_data),
    .out_valid(pix_valid),
    .out_ready(pix_ready),
    .out_data(o_data)
  );

  assign pix_data = o_data[2*VID_W-1:0];
  assign pix_dual = o_data[2*VID_W];
  assign pix_kind = o_data[FW-1:2*VID_W+1];
endmodule

// [verif/ccdr_sensor_model.sv]
// Behavioural sensor answering the serial gates with converter words
`timescale 1ns/10ps
module ccdr_sensor_model (
  // Serial gates
  input wire logic [1:0] serial_shift_gate,
  // Video
  output logic [11:0] video_out_a,
  output logic [11:0] video_out_b
);
  // ****
  // Registers
  // ****
  logic [7:0] n_a = 8'h0;
  logic [7:0] n_b = 8'h0;
  // High nibble names the output so a swapped path shows at once
  always @(posedge serial_shift_gate[0]) n_a <= n_a + 8'h1;
  always @(posedge serial_shift_gate[1]) n_b <= n_b + 8'h1;
  assign video_out_a = {4'hA, n_a};
  assign video_out_b = {4'hB, n_b};
endmodule

// [verif/ccdr_seq_bench.sv]
// Self-checking bench for the sensor drive sequencer
`timescale 1ns/10ps
module ccdr_seq_bench;
  import ccdr_pkg::*;
  localparam int ELEMS = 30;
  localparam int WORDS = DUMMY_ELEMS + ELEMS;
  // ****
  // Signals
  // ****
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic start = 1'b0;
  logic [1:0] mode = MODE_INTERLACE;
  logic clear_first = 1'b0;
  logic pix_ready = 1'b1;
  logic busy, field_two, image_gate_a, image_gate_b, storage_gate, reset_gate;
  logic overflow_drain_bias, clamp_strobe, sample_strobe, pix_valid, pix_dual;
  logic [1:0] serial_shift_gate, pix_kind;
  logic [11:0] video_out_a, video_out_b;
  logic [23:0] pix_data;
  logic ig_q = 1'b0;
  logic od_q = 1'b0;
  logic sa_q = 1'b0;
  logic exp_field = 1'b0;
  int n_fail = 0;
  int samples_checked = 0;
  int n_pulse, n_word, n_bad, n_clr, n_store;
  always #2 sys_clk = ~sys_clk;
  ccdr_seq #(
    .INTEG_CYCLES(16),
    .XFERS_F1(3),
    .XFERS_F2(4),
    .LINES(2),
    .ELEMS(ELEMS)
  ) dut_u (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .start(start),
    .mode(mode),
    .clear_first(clear_first),
    .busy(busy),
    .field_two(field_two),
    .image_gate_a(image_gate_a),
    .image_gate_b(image_gate_b),
    .storage_gate(storage_gate),
    .serial_shift_gate(serial_shift_gate),
    .reset_gate(reset_gate),
    .overflow_drain_bias(overflow_drain_bias),
    .clamp_strobe(clamp_strobe),
    .sample_strobe(sample_strobe),
    .video_out_a(video_out_a),
    .video_out_b(video_out_b),
    .pix_valid(pix_valid),
    .pix_ready(pix_ready),
    .pix_data(pix_data),
    .pix_kind(pix_kind),
    .pix_dual(pix_dual)
  );
  ccdr_sensor_model model_u (
    .serial_shift_gate(serial_shift_gate),
    .video_out_a(video_out_a),
    .video_out_b(video_out_b)
  );
  // Counts gate pulses and checks each word's source register
  always @(posedge sys_clk) begin
    ig_q <= image_gate_a;
    od_q <= overflow_drain_bias;
    sa_q <= storage_gate;
    if (image_gate_a && !ig_q) n_pulse++;
    if (overflow_drain_bias && !od_q) n_clr++;
    if (storage_gate && !sa_q) n_store++;
    if (pix_valid && pix_ready) begin
      n_word++;
      if (pix_data[11:8] !== ((mode == MODE_INTERLACE) ? 4'hB : 4'hA)) n_bad++;
      if (pix_dual !== (mode == MODE_PROG_DUAL)) n_bad++;
      if (pix_dual && pix_data[23:20] !== 4'hB) n_bad++;
    end
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (exp !== got) begin
      n_fail++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  // Stall holds the stream back so the FIFO fills and refuses
  task automatic run_field(input logic [1:0] m, input logic clr, input int pulses,
                           input int words, input int stall);
    int i;
    mode = m;
    clear_first = clr;
    n_pulse = 0;
    n_word = 0;
    n_bad = 0;
    n_clr = 0;
    n_store = 0;
    exp_field = !exp_field;
    pix_ready = 1'b0;
    start = 1'b1;
    @(posedge sys_clk);
    #1 start = 1'b0;
    for (i = 0; i < 20000 && (busy !== 1'b0 || n_word < words); i++) begin
      if (i >= stall) pix_ready = 1'b1;
      @(posedge sys_clk);
      #1;
    end
    repeat (10) @(posedge sys_clk);
    #1;
    check("clear pulses", clr, n_clr);
    check("parallel pulses", pulses, n_pulse);
    check("words", words, n_word);
    check("source errors", 0, n_bad);
    // Storage gate pulses once per parallel transfer and once per line shift
    check("storage pulses", pulses + words / WORDS, n_store);
    check("field flag", {31'h0, exp_field}, {31'h0, field_two});
  endtask
  task automatic t_frozen();
    clk_en = 1'b0;
    start = 1'b1;
    repeat (5) @(posedge sys_clk);
    #1 start = 1'b0;
    check("frozen busy", 0, {31'h0, busy});
    clk_en = 1'b1;
  endtask
  task automatic t_interlace_first();
    run_field(MODE_INTERLACE, 1'b1, 3, 2 * WORDS, 0);
  endtask
  task automatic t_interlace_second();
    run_field(MODE_INTERLACE, 1'b0, 4, 2 * WORDS, 0);
  endtask
  task automatic t_single();
    run_field(MODE_PROG_SINGLE, 1'b0, 3, 2 * WORDS, 0);
  endtask
  task automatic t_dual_stall();
    run_field(MODE_PROG_DUAL, 1'b1, 3, WORDS, 600);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    t_frozen();
    t_interlace_first();
    t_interlace_second();
    t_single();
    t_dual_stall();
    summarize();
  end
endmodule
bind ccdr_seq ccdr_seq_chk #(.ELEMS(ELEMS)) chk_u (
  .sys_clk(sys_clk),
  .sys_rst(sys_rst),
  .mode(mode),
  .busy(busy),
  .image_gate_a(image_gate_a),
  .image_gate_b(image_gate_b),
  .serial_shift_gate(serial_shift_gate),
  .reset_gate(reset_gate),
  .overflow_drain_bias(overflow_drain_bias),
  .clamp_strobe(clamp_strobe),
  .sample_strobe(sample_strobe),
  .pix_valid(pix_valid),
  .pix_ready(pix_ready),
  .pix_data(pix_data),
  .pix_kind(pix_kind)
);

// [verif/ccdr_seq_chk.sv]
// Checker of drive timing and pixel stream
`timescale 1ns/10ps
module ccdr_seq_chk
  import ccdr_pkg::*;
#(
  parameter int ELEMS = 30
) (
  // Clock
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Watched
  input wire logic [1:0] mode,
  input wire logic busy,
  input wire logic image_gate_a,
  input wire logic image_gate_b,
  input wire logic [1:0] serial_shift_gate,
  input wire logic reset_gate,
  input wire logic overflow_drain_bias,
  input wire logic clamp_strobe,
  input wire logic sample_strobe,
  input wire logic pix_valid,
  input wire logic pix_ready,
  input wire logic [2*VID_W-1:0] pix_data,
  input wire logic [1:0] pix_kind
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ****
  // Helpers
  // ****
  logic [8:0] hi_n;
  logic [9:0] idx;
  logic [1:0] kind;
  always_ff @(posedge sys_clk) begin
    hi_n <= (sys_rst || !overflow_drain_bias) ? 9'h0 : hi_n + 9'h1;
    if (sys_rst) begin
      idx <= 10'h0;
    end else if (pix_valid && pix_ready) begin
      idx <= (idx == 10'(DUMMY_ELEMS + ELEMS - 1)) ? 10'h0 : idx + 10'h1;
    end
  end
  // Kind follows position in line, not the sensor's phase
  always_comb begin
    kind = KIND_ACTIVE;
    if (idx < 10'(DUMMY_ELEMS + DARK_COLS)) kind = KIND_DARK;
    if (idx < 10'(DUMMY_ELEMS)) kind = KIND_DUMMY;
  end
  a_clear_width: assert property ($fell(overflow_drain_bias) |-> hi_n == 9'(CLEAR_CYC))
    else $error("clear pulse width wrong");
  a_gate_pulse: assert property (
    $rose(image_gate_a) |-> image_gate_a[*5] ##1 !image_gate_a)
    else $error("parallel pulse shape wrong");
  a_gates_pair: assert property (image_gate_a == image_gate_b)
    else $error("image gates differ");
  // Parallel transfer pulses all gates, so only the line and pixel phases count
  a_interlace_reg: assert property (
    busy && mode == MODE_INTERLACE && !image_gate_a |-> !serial_shift_gate[0])
    else $error("first register clocked in interlace");
  a_dual_pair: assert property (
    busy && mode == MODE_PROG_DUAL |-> serial_shift_gate[0] == serial_shift_gate[1])
    else $error("dual registers not together");
  a_pixel_phase: assert property (
    $rose(reset_gate) |-> reset_gate[*5] ##1 clamp_strobe[*5] ##1
    (serial_shift_gate != 2'h0)[*5] ##1 sample_strobe)
    else $error("pixel phase order wrong");
  a_kind_order: assert property (pix_valid |-> pix_kind == kind)
    else $error("pixel kind out of order");
  a_valid_hold: assert property (
    pix_valid && !pix_ready |=> pix_valid && $stable(pix_data))
    else $error("stalled word changed");
endmodule
